/* File: include/ssft_pkg.sv */
// Shared constants, encodings and carrier types for the segment and flag instruction decoder.
package ssft_pkg;

  // ==========================================================================
  // Opcode encodings
  // ==========================================================================
  localparam logic [7:0] OPC_ESCAPE = 8'h0f;
  localparam logic [7:0] POP_SEG_MASK = 8'he7;
  localparam logic [7:0] POP_SEG_PATTERN = 8'h07;
  localparam logic [7:0] POP_SEG2_MASK = 8'hc7;
  localparam logic [7:0] POP_SEG2_PATTERN = 8'h81;
  localparam logic [7:0] SWAP_MASK = 8'hf8;
  localparam logic [7:0] SWAP_PATTERN = 8'h90;
  localparam logic [7:0] OPC_LOAD_EFF_ADDR = 8'h8d;
  localparam logic [7:0] OPC_FAR_DATA = 8'hc5;
  localparam logic [7:0] OPC_FAR_EXTRA = 8'hc4;
  localparam logic [7:0] OPC2_FAR_STACK = 8'hb2;
  localparam logic [7:0] OPC2_FAR_THIRD = 8'hb4;
  localparam logic [7:0] OPC2_FAR_FOURTH = 8'hb5;
  localparam logic [7:0] OPC_CARRY_CLEAR = 8'hf8;
  localparam logic [7:0] OPC_CARRY_INVERT = 8'hf5;
  localparam logic [7:0] OPC_DIR_CLEAR = 8'hfc;
  localparam logic [7:0] OPC_IRQ_CLEAR = 8'hfa;
  localparam logic [7:0] OPC2_TS_CLEAR = 8'h06;
  localparam logic [7:0] OPC_FLAGS_TO_ACC = 8'h9f;

  // ==========================================================================
  // Field positions and selector codes
  // ==========================================================================
  localparam int SREG2_LSB = 3;
  localparam int MODRM_REG_LSB = 3;
  localparam int MODRM_MOD_LSB = 6;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [1:0] SREG2_CODE_SEG = 2'h1;
  localparam logic [2:0] SEL_EXTRA = 3'h0;
  localparam logic [2:0] SEL_STACK = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_THIRD = 3'h4;
  localparam logic [2:0] SEL_FOURTH = 3'h5;
  localparam int FLAG_CARRY_BIT = 0;

  // ==========================================================================
  // Clock counts (real or virtual-8086 / protected)
  // ==========================================================================
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CLK_POP_SEG_REAL = 5'h07;
  localparam logic [CNT_W-1:0] CLK_POP_SEG_PROT = 5'h15;
  localparam logic [CNT_W-1:0] CLK_SWAP = 5'h03;
  localparam logic [CNT_W-1:0] CLK_LOAD_EFF_ADDR = 5'h02;
  localparam logic [CNT_W-1:0] CLK_FAR_REAL = 5'h07;
  localparam logic [CNT_W-1:0] CLK_FAR_PROT = 5'h16;
  localparam logic [CNT_W-1:0] CLK_FAR2_PROT = 5'h19;
  localparam logic [CNT_W-1:0] CLK_FLAG_SIMPLE = 5'h02;
  localparam logic [CNT_W-1:0] CLK_IRQ_CLEAR = 5'h08;
  localparam logic [CNT_W-1:0] CLK_TS_CLEAR = 5'h06;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_DIRECTION = 1'b0;
  localparam logic RST_IRQ_ENABLE = 1'b0;
  localparam logic RST_TASK_SWITCHED = 1'b0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    none_op,
    seg_pop_op,
    swap_op,
    load_eff_addr_op,
    far_load_op,
    carry_clear_op,
    carry_invert_op,
    direction_clear_op,
    irq_enable_clear_op,
    task_switched_clear_op,
    flags_to_acc_high_op
  } ssft_op_t;

  typedef struct packed {
    ssft_op_t op;
    logic [2:0] sel;
    logic [2:0] reg_idx;
    logic mem;
    logic prot;
  } ssft_exec_t;

  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [15:0] val;
  } ssft_seg_wr_t;

  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [31:0] val;
  } ssft_reg_wr_t;

endpackage : ssft_pkg

/* File: core/ssft_cycle_timer.sv */
// Execution clock counter that stretches by one cycle for each wait-stated cycle.
`timescale 1ns/100ps
module ssft_cycle_timer (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [ssft_pkg::CNT_W-1:0] i_count,
  input wire logic i_stall,
  output logic o_last
);

  // ==========================================================================
  // Down counter
  // ==========================================================================
  logic [ssft_pkg::CNT_W-1:0] cnt_ff;

  // A stalled cycle holds the count, so each wait state adds exactly one clock.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= '0;
    end else if (i_load) begin
      cnt_ff <= i_count;
    end else if ((cnt_ff != '0) && !i_stall) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Last productive cycle of the instruction.
  assign o_last = (cnt_ff == {{(ssft_pkg::CNT_W-1){1'b0}}, 1'b1}) && !i_stall;

endmodule : ssft_cycle_timer

/* File: core/ssft_decoder.sv */
// Decoder and clock-count sequencer for segment pops, swaps, far loads and flag control.
// ============================================================================
// ============================================================================
`timescale 1ns/100ps
module ssft_decoder (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_byte_vld,
  input wire logic [7:0] i_byte,
  input wire logic i_prot_mode,
  input wire logic i_wait,
  input wire logic [15:0] i_mem_sel,
  input wire logic [31:0] i_mem_offset,
  input wire logic [31:0] i_eff_addr,
  input wire logic [7:0] i_flags_low,
  output logic o_byte_rdy,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output ssft_pkg::ssft_exec_t o_cur,
  output ssft_pkg::ssft_seg_wr_t o_seg_wr,
  output ssft_pkg::ssft_reg_wr_t o_dest_wr,
  output logic o_swap_req,
  output logic [2:0] o_swap_idx,
  output logic o_acc_high_we,
  output logic [7:0] o_acc_high_byte,
  output logic o_carry,
  output logic o_direction,
  output logic o_irq_enable,
  output logic o_task_switched
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [1:0] {st_opcode, st_escape, st_modrm, st_exec} ssft_state_t;

  ssft_state_t state_ff;
  ssft_state_t nxt_state;
  ssft_pkg::ssft_exec_t cur_ff;
  ssft_pkg::ssft_exec_t nxt_cur;
  logic nxt_illegal;
  logic take;
  logic start;
  logic last;
  logic [ssft_pkg::CNT_W-1:0] start_count;
  logic done_ff;
  logic illegal_ff;
  logic carry_ff;
  logic direction_ff;
  logic irq_enable_ff;
  logic task_switched_ff;
  ssft_pkg::ssft_seg_wr_t seg_wr_ff;
  ssft_pkg::ssft_reg_wr_t dest_wr_ff;
  logic swap_req_ff;
  logic [2:0] swap_idx_ff;
  logic acc_high_we_ff;
  logic [7:0] acc_high_ff;
  logic rdy_ff;
  logic busy_ff;

  localparam int SREG_FIELD_HI = ssft_pkg::SREG2_LSB + 1;
  localparam int MODRM_REG_HI = ssft_pkg::MODRM_REG_LSB + 2;

  assign take = i_byte_vld && (state_ff != st_exec);

  // Picks the column for the mode and the operand kind; unused pairs pass equal values.
  function automatic logic [ssft_pkg::CNT_W-1:0] pick_count(
    input logic prot,
    input logic mem,
    input logic [ssft_pkg::CNT_W-1:0] real_reg,
    input logic [ssft_pkg::CNT_W-1:0] real_mem,
    input logic [ssft_pkg::CNT_W-1:0] prot_reg,
    input logic [ssft_pkg::CNT_W-1:0] prot_mem
  );
    if (prot) begin
      pick_count = mem ? prot_mem : prot_reg;
    end else begin
      pick_count = mem ? real_mem : real_reg;
    end
  endfunction : pick_count

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Byte-by-byte decode; the mode is sampled in the cycle execution starts.
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_illegal = 1'b0;
    start = 1'b0;
    case (state_ff)
      st_opcode: begin
        if (take) begin
          nxt_cur.op = ssft_pkg::none_op;
          nxt_cur.sel = {1'b0, i_byte[SREG_FIELD_HI:ssft_pkg::SREG2_LSB]};
          nxt_cur.reg_idx = i_byte[2:0];
          nxt_cur.mem = 1'b0;
          nxt_cur.prot = i_prot_mode;
          nxt_state = st_exec;
          start = 1'b1;
          if (i_byte == ssft_pkg::OPC_ESCAPE) begin
            nxt_state = st_escape;
            start = 1'b0;
          end else if (((i_byte & ssft_pkg::POP_SEG_MASK) == ssft_pkg::POP_SEG_PATTERN)
                       && (i_byte[4:3] != ssft_pkg::SREG2_CODE_SEG)) begin
            nxt_cur.op = ssft_pkg::seg_pop_op;
            nxt_cur.sel = {1'b0, i_byte[4:3]};
            nxt_cur.mem = 1'b1;
          end else if ((i_byte & ssft_pkg::SWAP_MASK) == ssft_pkg::SWAP_PATTERN) begin
            nxt_cur.op = ssft_pkg::swap_op;
          end else if (i_byte == ssft_pkg::OPC_LOAD_EFF_ADDR) begin
            nxt_cur.op = ssft_pkg::load_eff_addr_op;
            nxt_state = st_modrm;
            start = 1'b0;
          end else if (i_byte == ssft_pkg::OPC_FAR_DATA) begin
            nxt_cur.op = ssft_pkg::far_load_op;
            nxt_cur.sel = ssft_pkg::SEL_DATA;
            nxt_state = st_modrm;
            start = 1'b0;
          end else if (i_byte == ssft_pkg::OPC_FAR_EXTRA) begin
            nxt_cur.op = ssft_pkg::far_load_op;
            nxt_cur.sel = ssft_pkg::SEL_EXTRA;
            nxt_state = st_modrm;
            start = 1'b0;
          end else if (i_byte == ssft_pkg::OPC_CARRY_CLEAR) begin
            nxt_cur.op = ssft_pkg::carry_clear_op;
          end else if (i_byte == ssft_pkg::OPC_CARRY_INVERT) begin
            nxt_cur.op = ssft_pkg::carry_invert_op;
          end else if (i_byte == ssft_pkg::OPC_DIR_CLEAR) begin
            nxt_cur.op = ssft_pkg::direction_clear_op;
          end else if (i_byte == ssft_pkg::OPC_IRQ_CLEAR) begin
            nxt_cur.op = ssft_pkg::irq_enable_clear_op;
          end else if (i_byte == ssft_pkg::OPC_FLAGS_TO_ACC) begin
            nxt_cur.op = ssft_pkg::flags_to_acc_high_op;
          end else begin
            nxt_state = st_opcode;
            start = 1'b0;
            nxt_illegal = 1'b1;
          end
        end
      end
      st_escape: begin
        if (take) begin
          nxt_cur.prot = i_prot_mode;
          nxt_state = st_exec;
          start = 1'b1;
          // Only the third and fourth selectors have an escaped pop; codes 6 and 7 are refused.
          if ((i_byte & ssft_pkg::POP_SEG2_MASK) == ssft_pkg::POP_SEG2_PATTERN
              && (i_byte[5:3] == ssft_pkg::SEL_THIRD
                  || i_byte[5:3] == ssft_pkg::SEL_FOURTH)) begin
            nxt_cur.op = ssft_pkg::seg_pop_op;
            nxt_cur.sel = i_byte[5:3];
            nxt_cur.mem = 1'b1;
          end else if (i_byte == ssft_pkg::OPC2_TS_CLEAR) begin
            nxt_cur.op = ssft_pkg::task_switched_clear_op;
          end else if (i_byte == ssft_pkg::OPC2_FAR_STACK) begin
            nxt_cur.op = ssft_pkg::far_load_op;
            nxt_cur.sel = ssft_pkg::SEL_STACK;
            nxt_state = st_modrm;
            start = 1'b0;
          end else if (i_byte == ssft_pkg::OPC2_FAR_THIRD
                       || i_byte == ssft_pkg::OPC2_FAR_FOURTH) begin
            nxt_cur.op = ssft_pkg::far_load_op;
            nxt_cur.sel = i_byte[0] ? ssft_pkg::SEL_FOURTH : ssft_pkg::SEL_THIRD;
            nxt_state = st_modrm;
            start = 1'b0;
          end else begin
            nxt_state = st_opcode;
            start = 1'b0;
            nxt_illegal = 1'b1;
          end
        end
      end
      st_modrm: begin
        if (take) begin
          nxt_cur.reg_idx = i_byte[MODRM_REG_HI:ssft_pkg::MODRM_REG_LSB];
          nxt_cur.mem = (i_byte[7:ssft_pkg::MODRM_MOD_LSB] != ssft_pkg::MOD_REGISTER);
          nxt_cur.prot = i_prot_mode;
          // A far pointer must come from memory; a register form is refused.
          if (cur_ff.op == ssft_pkg::far_load_op && !nxt_cur.mem) begin
            nxt_state = st_opcode;
            nxt_illegal = 1'b1;
          end else begin
            nxt_state = st_exec;
            start = 1'b1;
          end
        end
      end
      st_exec: begin
        if (last) begin
          nxt_state = st_opcode;
        end
      end
      default: begin
        nxt_state = st_opcode;
      end
    endcase
  end

  // Count for the instruction about to start, from its mode column.
  always_comb begin
    case (nxt_cur.op)
      ssft_pkg::seg_pop_op: begin
        start_count = nxt_cur.prot ? ssft_pkg::CLK_POP_SEG_PROT
                                   : ssft_pkg::CLK_POP_SEG_REAL;
      end
      ssft_pkg::swap_op: begin
        start_count = ssft_pkg::CLK_SWAP;
      end
      ssft_pkg::load_eff_addr_op: begin
        start_count = ssft_pkg::CLK_LOAD_EFF_ADDR;
      end
      ssft_pkg::far_load_op: begin
        start_count = pick_count(nxt_cur.prot, nxt_cur.mem, ssft_pkg::CLK_FAR_REAL,
                                 ssft_pkg::CLK_FAR_REAL,
                                 (nxt_cur.sel >= ssft_pkg::SEL_THIRD) ?
                                 ssft_pkg::CLK_FAR2_PROT : ssft_pkg::CLK_FAR_PROT,
                                 (nxt_cur.sel >= ssft_pkg::SEL_THIRD) ?
                                 ssft_pkg::CLK_FAR2_PROT : ssft_pkg::CLK_FAR_PROT);
      end
      ssft_pkg::irq_enable_clear_op: begin
        start_count = ssft_pkg::CLK_IRQ_CLEAR;
      end
      ssft_pkg::task_switched_clear_op: begin
        start_count = ssft_pkg::CLK_TS_CLEAR;
      end
      default: begin
        start_count = ssft_pkg::CLK_FLAG_SIMPLE;
      end
    endcase
  end

  // Waits stretch execution; the counter freezes on any wait-stated cycle.
  ssft_cycle_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(start),
    .i_count(start_count),
    .i_stall(i_wait),
    .o_last(last)
  );

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= st_opcode;
      cur_ff <= '0;
      illegal_ff <= 1'b0;
      done_ff <= 1'b0;
      rdy_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rdy_ff <= (nxt_state != st_exec); // Registered so the port needs no decode.
      busy_ff <= (nxt_state == st_exec);
      cur_ff <= nxt_cur;
      illegal_ff <= nxt_illegal;
      done_ff <= (state_ff == st_exec) && last;
    end
  end

  // ==========================================================================
  // Architectural flags
  // ==========================================================================
  // Flags change only in the final cycle, so a stalled instruction has no early effect.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      carry_ff <= ssft_pkg::RST_CARRY;
      direction_ff <= ssft_pkg::RST_DIRECTION;
      irq_enable_ff <= ssft_pkg::RST_IRQ_ENABLE;
      task_switched_ff <= ssft_pkg::RST_TASK_SWITCHED;
    end else if (state_ff == st_exec && last) begin
      if (cur_ff.op == ssft_pkg::carry_clear_op) begin
        carry_ff <= 1'b0;
      end
      if (cur_ff.op == ssft_pkg::carry_invert_op) begin
        carry_ff <= ~carry_ff;
      end
      if (cur_ff.op == ssft_pkg::direction_clear_op) begin
        direction_ff <= 1'b0;
      end
      if (cur_ff.op == ssft_pkg::irq_enable_clear_op) begin
        irq_enable_ff <= 1'b0;
      end
      if (cur_ff.op == ssft_pkg::task_switched_clear_op) begin
        task_switched_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Result writes
  // ==========================================================================
  // One-cycle write strobes issued together with the completion pulse.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seg_wr_ff <= '0;
      dest_wr_ff <= '0;
      swap_req_ff <= 1'b0;
      swap_idx_ff <= 3'h0;
      acc_high_we_ff <= 1'b0;
      acc_high_ff <= 8'h00;
    end else begin
      seg_wr_ff.we <= 1'b0;
      dest_wr_ff.we <= 1'b0;
      swap_req_ff <= 1'b0;
      acc_high_we_ff <= 1'b0;
      if (state_ff == st_exec && last) begin
        case (cur_ff.op)
          ssft_pkg::seg_pop_op: begin
            seg_wr_ff <= '{we: 1'b1, idx: cur_ff.sel, val: i_mem_sel};
          end
          ssft_pkg::far_load_op: begin
            seg_wr_ff <= '{we: 1'b1, idx: cur_ff.sel, val: i_mem_sel};
            dest_wr_ff <= '{we: 1'b1, idx: cur_ff.reg_idx, val: i_mem_offset};
          end
          ssft_pkg::load_eff_addr_op: begin
            dest_wr_ff <= '{we: 1'b1, idx: cur_ff.reg_idx, val: i_eff_addr};
          end
          ssft_pkg::swap_op: begin
            swap_req_ff <= 1'b1;
            swap_idx_ff <= cur_ff.reg_idx;
          end
          ssft_pkg::flags_to_acc_high_op: begin
            acc_high_we_ff <= 1'b1;
            acc_high_ff <= {i_flags_low[7:1], carry_ff};
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_byte_rdy = rdy_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_illegal = illegal_ff;
  assign o_cur = cur_ff;
  assign o_seg_wr = seg_wr_ff;
  assign o_dest_wr = dest_wr_ff;
  assign o_swap_req = swap_req_ff;
  assign o_swap_idx = swap_idx_ff;
  assign o_acc_high_we = acc_high_we_ff;
  assign o_acc_high_byte = acc_high_ff;
  assign o_carry = carry_ff;
  assign o_direction = direction_ff;
  assign o_irq_enable = irq_enable_ff;
  assign o_task_switched = task_switched_ff;

endmodule : ssft_decoder

/* File: sim/ssft_decoder_props.sv */
// Concurrent checks on the ports of the segment and flag instruction decoder.
`timescale 1ns/100ps
module ssft_decoder_props (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wait,
  input wire logic [15:0] i_mem_sel,
  input wire logic o_byte_rdy,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire ssft_pkg::ssft_exec_t o_cur,
  input wire ssft_pkg::ssft_seg_wr_t o_seg_wr,
  input wire logic o_acc_high_we,
  input wire logic [7:0] o_acc_high_byte,
  input wire logic o_carry,
  input wire logic o_direction,
  input wire logic o_irq_enable,
  input wire logic o_task_switched
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // =====
  // Helper logic
  // Counts busy cycles that were not wait states, so waits never mask a wrong count.
  logic [5:0] run_ff;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_ff <= 6'h00;
    end else if (o_busy) begin
      run_ff <= run_ff + {5'h00, !i_wait};
    end else begin
      run_ff <= 6'h00;
    end
  end

  // Listed figure for the decoded instruction, worked out apart from the design.
  function automatic logic [5:0] listed(input ssft_pkg::ssft_exec_t c);
    case (c.op)
      ssft_pkg::seg_pop_op: return c.prot ? 6'h15 : 6'h07;
      ssft_pkg::swap_op: return 6'h03;
      ssft_pkg::far_load_op: return !c.prot ? 6'h07 : ((c.sel > 3'h3) ? 6'h19 : 6'h16);
      ssft_pkg::irq_enable_clear_op: return 6'h08;
      ssft_pkg::task_switched_clear_op: return 6'h06;
      default: return 6'h02;
    endcase
  endfunction : listed

  // =====
  // Assertions
  a_busy_blocks_rdy: assert property (o_busy |-> !o_byte_rdy)
    else $error("byte ready while busy");
  a_busy_ends_done: assert property ($fell(o_busy) |-> o_done)
    else $error("busy fell without done");
  a_wait_holds_busy: assert property (o_busy && i_wait |=> o_busy)
    else $error("wait state did not extend execution");
  a_listed_count: assert property (
    o_done |-> run_ff == listed(o_cur))
    else $error("execution clock count wrong");
  a_carry_clear: assert property (o_done && o_cur.op == ssft_pkg::carry_clear_op
    |-> !o_carry)
    else $error("carry not cleared");
  a_carry_invert: assert property ($rose(o_busy)
    && o_cur.op == ssft_pkg::carry_invert_op && !i_wait ##1 !i_wait
    |=> o_carry != $past(o_carry, 2))
    else $error("carry not inverted");
  a_dir_clear: assert property (o_done && o_cur.op == ssft_pkg::direction_clear_op
    |-> !o_direction)
    else $error("direction not cleared");
  a_irq_clear: assert property (o_done && o_cur.op == ssft_pkg::irq_enable_clear_op
    |-> !o_irq_enable)
    else $error("interrupt enable not cleared");
  a_ts_clear: assert property (o_done && o_cur.op == ssft_pkg::task_switched_clear_op
    |-> !o_task_switched)
    else $error("task switched bit not cleared");
  a_acc_high_copy: assert property (o_acc_high_we
    |-> o_done && o_acc_high_byte[0] == o_carry)
    else $error("accumulator high byte wrong");
  a_seg_wr_value: assert property (o_seg_wr.we
    |-> o_done && o_seg_wr.val == $past(i_mem_sel))
    else $error("segment write value wrong");
  a_illegal_idle: assert property (o_illegal |-> !o_busy)
    else $error("refused form started execution");
endmodule : ssft_decoder_props

bind ssft_decoder ssft_decoder_props i_props (.i_clk, .i_nrst, .i_wait, .i_mem_sel, .o_byte_rdy,
  .o_busy, .o_done, .o_illegal, .o_cur, .o_seg_wr, .o_acc_high_we, .o_acc_high_byte, .o_carry,
  .o_direction, .o_irq_enable, .o_task_switched);

/* File: sim/ssft_decoder_tb.sv */
// Self-checking bench for the segment and flag instruction decoder.
`timescale 1ns/100ps
module ssft_decoder_tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_byte_vld = 1'b0;
  logic [7:0] i_byte = 8'h00;
  logic i_prot_mode = 1'b0;
  logic i_wait = 1'b0;
  logic [15:0] i_mem_sel = 16'h5a3c;
  logic [31:0] i_mem_offset = 32'h1234_5678;
  logic [31:0] i_eff_addr = 32'h0bad_f00d;
  logic [7:0] i_flags_low = 8'ha6;
  logic o_byte_rdy, o_busy, o_done, o_illegal, o_swap_req, o_acc_high_we;
  logic o_carry, o_direction, o_irq_enable, o_task_switched;
  logic [2:0] o_swap_idx;
  logic [7:0] o_acc_high_byte;
  ssft_pkg::ssft_exec_t o_cur;
  ssft_pkg::ssft_seg_wr_t o_seg_wr;
  ssft_pkg::ssft_reg_wr_t o_dest_wr;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  // The clock flips every 25 ns, half of its 50 ns period.
  always #25 i_clk = ~i_clk;

  ssft_decoder i_dut (.i_clk, .i_nrst, .i_byte_vld, .i_byte, .i_prot_mode, .i_wait, .i_mem_sel,
    .i_mem_offset, .i_eff_addr, .i_flags_low, .o_byte_rdy, .o_busy, .o_done, .o_illegal, .o_cur,
    .o_seg_wr, .o_dest_wr, .o_swap_req, .o_swap_idx, .o_acc_high_we, .o_acc_high_byte, .o_carry,
    .o_direction, .o_irq_enable, .o_task_switched);

  // Guards against a hang; the whole run needs well under a thousand cycles.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // =====
  // Shared tasks
  task automatic stop_test;
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Offers bytes back to back from a falling edge; leaves valid low afterwards.
  task automatic feed(input logic [23:0] seq, input int n, input logic prot);
    for (int k = 0; k < n; k++) begin
      i_byte_vld = 1'b1;
      i_byte = seq[8*(n-1-k) +: 8];
      i_prot_mode = prot;
      @(negedge i_clk);
    end
    i_byte_vld = 1'b0;
  endtask : feed

  // Mode flips once execution starts, so a late mode sample would show as a wrong count.
  task automatic exec(input logic [23:0] seq, input int n, input logic prot, input int nw,
                      input int exp);
    int cnt;
    cnt = 0;
    feed(seq, n, prot);
    i_prot_mode = ~prot;
    while (o_busy === 1'b1 && cnt < 40) begin
      i_wait = (cnt < nw);
      cnt++;
      @(negedge i_clk);
    end
    i_wait = 1'b0;
    chk("busy_cycles", 32'(exp + nw), 32'(cnt));
    chk("done", 32'h1, {31'h0, o_done});
  endtask : exec

  // =====
  // Scenarios
  task automatic t_seg_loads;
    logic [23:0] seq [10] = '{24'h000007, 24'h000017, 24'h00001f, 24'h000fa1, 24'h000fa9,
      24'h00c50e, 24'h00c40e, 24'h0fb20e, 24'h0fb40e, 24'h0fb50e};
    int n [10] = '{1, 1, 1, 2, 2, 2, 2, 3, 3, 3};
    logic [2:0] sel [10] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h0, 3'h2, 3'h4, 3'h5};
    int pc [10] = '{21, 21, 21, 21, 21, 22, 22, 22, 25, 25};
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 10; k++) begin
        exec(seq[k], n[k], m[0], 0, m ? pc[k] : 7);
        chk("seg_wr", {28'h0, 1'b1, sel[k]}, {28'h0, o_seg_wr.we, o_seg_wr.idx});
        chk("seg_val", {16'h0, i_mem_sel}, {16'h0, o_seg_wr.val});
        if (k > 4) begin
          chk("far_dst", 32'h9, {28'h0, o_dest_wr.we, o_dest_wr.idx});
          chk("far_off", i_mem_offset, o_dest_wr.val);
        end
      end
    end
  endtask : t_seg_loads

  task automatic t_lea;
    exec(24'h008d5e, 2, 1'b1, 0, 2);
    chk("lea_dst", 32'hb, {28'h0, o_dest_wr.we, o_dest_wr.idx});
    chk("lea_val", i_eff_addr, o_dest_wr.val);
    exec(24'h008d96, 2, 1'b0, 0, 2);
    chk("lea_dst2", 32'ha, {28'h0, o_dest_wr.we, o_dest_wr.idx});
  endtask : t_lea

  task automatic t_swap;
    for (int r = 0; r < 8; r++) begin
      exec({16'h0, 5'h12, r[2:0]}, 1, r[0], 0, 3);
      chk("swap", {28'h0, 1'b1, r[2:0]}, {28'h0, o_swap_req, o_swap_idx});
    end
  endtask : t_swap

  task automatic t_flags;
    exec(24'h0000f5, 1, 1'b0, 0, 2);
    chk("carry_inv", 32'h1, {31'h0, o_carry});
    exec(24'h00009f, 1, 1'b1, 0, 2);
    chk("acc_high", {23'h0, 1'b1, i_flags_low[7:1], 1'b1},
        {23'h0, o_acc_high_we, o_acc_high_byte});
    exec(24'h0000f8, 1, 1'b1, 0, 2);
    chk("carry_clr", 32'h0, {31'h0, o_carry});
    exec(24'h00009f, 1, 1'b0, 0, 2);
    chk("acc_high0", {24'h0, i_flags_low[7:1], 1'b0}, {24'h0, o_acc_high_byte});
    exec(24'h0000fc, 1, 1'b0, 0, 2);
    chk("direction", 32'h0, {31'h0, o_direction});
    exec(24'h0000fa, 1, 1'b1, 0, 8);
    chk("irq_enable", 32'h0, {31'h0, o_irq_enable});
    exec(24'h000f06, 2, 1'b1, 0, 6);
    chk("task_sw", 32'h0, {31'h0, o_task_switched});
  endtask : t_flags

  task automatic t_wait;
    exec(24'h0000fa, 1, 1'b1, 3, 8);
    exec(24'h000fa9, 2, 1'b1, 1, 21);
    exec(24'h0fb40e, 3, 1'b0, 2, 7);
  endtask : t_wait

  // Unknown opcode, unknown escape follow-on, a far load with a register operand
  // and an escaped pop of a selector code that has no pop.
  task automatic t_illegal;
    logic [23:0] seq [4] = '{24'h000000, 24'h000f00, 24'h00c5c8, 24'h000fb1};
    int n [4] = '{1, 2, 2, 2};
    for (int k = 0; k < 4; k++) begin
      feed(seq[k], n[k], 1'b0);
      chk("illegal", 32'h2, {30'h0, o_illegal, o_busy});
    end
  endtask : t_illegal

  // =====
  // Main sequence
  initial begin
    repeat (10) @(negedge i_clk);
    i_nrst = 1'b1;
    t_seg_loads();
    t_lea();
    t_swap();
    t_flags();
    t_wait();
    t_illegal();
    stop_test();
  end
endmodule : ssft_decoder_tb
